// >>> timer_set_pkg.sv
// shared constants for the general purpose timer set
package timer_set_pkg;
    localparam int NUM_TIMERS = 5;
    localparam int MAX_CH = 4;
    localparam int WIDE_W = 32;
    localparam int NARROW_W = 16;
    localparam int PSC_W = 16;
    // timer slots inside the set
    localparam int WIDE_IDX = 0;
    localparam int NARROW_IDX = 1;
    localparam int FIRST_SINGLE_IDX = 2;
    // channel count of the dual-direction and the single-channel timers
    localparam int DUAL_CH = 4;
    localparam int SINGLE_CH = 1;
    // channel modes
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_ONE_PULSE = 2'h3;
    // trigger source of a dual-direction timer
    localparam logic [1:0] TRIG_NONE = 2'h0;
    localparam logic [1:0] TRIG_ADVANCED = 2'h1;
    localparam logic [1:0] TRIG_PARTNER = 2'h2;
    // hall mode watches this many sensor lines
    localparam int HALL_LINES = 3;
endpackage

// >>> general_purpose_timer_set.sv
// five general purpose timers: counters, prescalers, channels, encoder and trigger chain
`timescale 1ns/10ps
`default_nettype none

module timer_core #(
    parameter int CW = 16,
    parameter int NCH = 1,
    parameter bit DIR_EN = 1'b0
) (
    input wire logic clk,                        // timer clock
    input wire logic rst_b,                      // async reset, active low
    input wire logic en_i,                       // counter enable
    input wire logic dir_down_i,                 // count down when set
    input wire logic run_i,                      // low while frozen for debug
    input wire logic enc_mode_i,                 // quadrature encoder counting
    input wire logic hall_mode_i,                // hall sensor capture on channel 0
    input wire logic trig_i,                     // restart pulse from the chain
    input wire logic [15:0] psc_i,               // prescaler value
    input wire logic [CW-1:0] arr_i,             // auto-reload value
    input wire logic [NCH-1:0][1:0] mode_i,      // channel modes
    input wire logic [NCH-1:0][CW-1:0] cmp_i,    // channel compare values
    input wire logic [NCH-1:0] ch_in_i,          // filtered channel inputs
    output logic [CW-1:0] cnt_o,                 // counter value
    output logic upd_o,                          // update event pulse
    output logic [NCH-1:0] ch_out_o,             // channel outputs
    output logic [NCH-1:0][CW-1:0] cap_o,        // captured values
    output logic [NCH-1:0] cc_o,                 // channel event pulses
    output logic dma_o                           // dma request pulse
);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [15:0] psc_cnt_r, psc_cnt_nxt, psc_act_r, psc_act_nxt;
    logic upd_r, upd_nxt, dma_r, dma_nxt, step, down;
    logic [NCH-1:0] prev_r, prev_nxt, out_r, out_nxt, cc_r, cc_nxt, done_r, done_nxt;
    logic [NCH-1:0][CW-1:0] cap_r, cap_nxt;
    logic [3:0] ch4, prev4;
    logic a_edge, hall_chg, ev;

    assign ch4 = 4'(ch_in_i);
    assign prev4 = 4'(prev_r);
    assign a_edge = ch4[0] ^ prev4[0];
    // hall: any change on the xor of the sensor lines
    assign hall_chg = (^ch4[timer_set_pkg::HALL_LINES-1:0])
        ^ (^prev4[timer_set_pkg::HALL_LINES-1:0]);

    always_comb begin
        cnt_nxt = cnt_r;
        psc_cnt_nxt = psc_cnt_r;
        psc_act_nxt = psc_act_r;
        upd_nxt = 1'b0;
        step = 1'b0;
        prev_nxt = ch_in_i;
        out_nxt = out_r;
        cc_nxt = '0;
        done_nxt = done_r;
        cap_nxt = cap_r;
        ev = 1'b0;
        down = DIR_EN && (enc_mode_i ? ~(ch4[0] ^ ch4[1]) : dir_down_i);
        if (en_i && run_i) begin
            if (trig_i) begin
                cnt_nxt = '0;
                psc_cnt_nxt = '0;
                upd_nxt = 1'b1;
            end else begin
                if (DIR_EN && enc_mode_i) begin
                    step = a_edge;
                end else if (psc_cnt_r >= psc_act_r) begin
                    psc_cnt_nxt = '0;
                    step = 1'b1;
                end else begin
                    psc_cnt_nxt = psc_cnt_r + 16'h1;
                end
                if (step) begin
                    if (down) begin
                        if (cnt_r == '0) begin
                            cnt_nxt = arr_i;
                            upd_nxt = 1'b1;
                        end else begin
                            cnt_nxt = cnt_r - CW'(1);
                        end
                    end else if (cnt_r >= arr_i) begin
                        cnt_nxt = '0;
                        upd_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + CW'(1);
                    end
                end
            end
        end
        if (upd_nxt) begin
            psc_act_nxt = psc_i;
        end
        for (int k = 0; k < NCH; k++) begin
            case (mode_i[k])
                timer_set_pkg::MODE_CAPTURE: begin
                    out_nxt[k] = 1'b0;
                    ev = (hall_mode_i && k == 0) ? hall_chg : (ch_in_i[k] && !prev_r[k]);
                    if (ev) begin
                        cap_nxt[k] = cnt_r;
                        cc_nxt[k] = 1'b1;
                    end
                end
                timer_set_pkg::MODE_COMPARE: begin
                    if (step && cnt_r == cmp_i[k]) begin
                        out_nxt[k] = !out_r[k];
                        cc_nxt[k] = 1'b1;
                    end
                end
                timer_set_pkg::MODE_PWM: begin
                    out_nxt[k] = cnt_r < cmp_i[k];
                end
                timer_set_pkg::MODE_ONE_PULSE: begin
                    // a single pulse per enable; re-arm by dropping the enable
                    if (upd_nxt) begin
                        done_nxt[k] = 1'b1;
                    end
                    out_nxt[k] = !done_r[k] && en_i && (cnt_r < cmp_i[k]);
                end
                default: begin
                    out_nxt[k] = 1'b0;
                end
            endcase
            if (!en_i) begin
                done_nxt[k] = 1'b0;
            end
        end
        dma_nxt = upd_nxt || (|cc_nxt);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
            psc_cnt_r <= 16'h0;
            psc_act_r <= 16'h0;
            upd_r <= 1'b0;
            dma_r <= 1'b0;
            prev_r <= '0;
            out_r <= '0;
            cc_r <= '0;
            done_r <= '0;
            cap_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            psc_cnt_r <= psc_cnt_nxt;
            psc_act_r <= psc_act_nxt;
            upd_r <= upd_nxt;
            dma_r <= dma_nxt;
            prev_r <= prev_nxt;
            out_r <= out_nxt;
            cc_r <= cc_nxt;
            done_r <= done_nxt;
            cap_r <= cap_nxt;
        end
    end

    assign cnt_o = cnt_r;
    assign upd_o = upd_r;
    assign ch_out_o = out_r;
    assign cap_o = cap_r;
    assign cc_o = cc_r;
    assign dma_o = dma_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    wrap_up_a: assert property (
        step && !down && !trig_i && en_i && run_i && cnt_r == arr_i |=> cnt_r == '0 && upd_r)
        else $error("up count did not wrap to zero at reload");
    wrap_down_a: assert property (
        step && down && !trig_i && en_i && run_i && cnt_r == '0 |=> cnt_r == $past(arr_i) && upd_r)
        else $error("down count did not reload at zero");
    debug_freeze_a: assert property (
        !run_i |=> $stable(cnt_r) && !upd_r)
        else $error("counter moved while frozen");
    psc_hold_a: assert property (
        !upd_nxt |=> psc_act_r == $past(psc_act_r))
        else $error("prescaler changed outside update");
    pwm_level_a: assert property (
        mode_i[0] == timer_set_pkg::MODE_PWM |=> ch_out_o[0] == ($past(cnt_r) < $past(cmp_i[0])))
        else $error("pwm level does not follow compare");
    chain_restart_a: assert property (
        trig_i && en_i && run_i |=> cnt_r == '0 ##0 upd_r)
        else $error("trigger did not restart counter");
    dma_follow_a: assert property (
        upd_r || (|cc_r) |-> dma_o)
        else $error("event raised no dma request");
    capture_value_a: assert property (
        cc_nxt[0] && mode_i[0] == timer_set_pkg::MODE_CAPTURE |=> cap_o[0] == $past(cnt_r) && cc_o[0])
        else $error("capture did not latch counter");
    up_only_a: assert property (
        !DIR_EN && $changed(cnt_r) |-> cnt_r == '0 || cnt_r == $past(cnt_r) + CW'(1))
        else $error("upcounter moved other than up");

    update_seen_c: cover property (upd_r);
    pwm_toggle_c: cover property (mode_i[0] == timer_set_pkg::MODE_PWM ##1 $rose(ch_out_o[0]));
    capture_seen_c: cover property (cc_o[0] && mode_i[0] == timer_set_pkg::MODE_CAPTURE);
    enc_down_c: cover property (enc_mode_i && step && down);
endmodule

// Functional notes
// - The wide dual-direction timer counts up or down on 32 bits behind a 16-bit prescaler.
// - The narrow dual-direction timer counts up or down on 16 bits behind a 16-bit prescaler.
// - Each dual-direction timer has four channels for capture, compare, pwm or one pulse.
// - The dual-direction timers restart from each other or the advanced control timer.
// - Each dual-direction timer raises its own dma requests.
// - The dual-direction timers count quadrature encoders and capture hall sensor changes.
// - The dual-direction counters stop while the core is halted and freeze is chosen.
// - The first single-channel timer counts up only on 16 bits behind a 16-bit prescaler.
// - The first single-channel timer has one channel with all four channel modes.
// - The first single-channel counter can freeze while the core is halted.
// - The second and third single-channel timers count up on 16 bits with a prescaler.
// - The second and third single-channel timers each have one channel with all modes.
// - Every timer works as a pwm generator or as a periodic time base.
module general_purpose_timer_set #(
    parameter int WIDE_W = timer_set_pkg::WIDE_W,
    parameter int NARROW_W = timer_set_pkg::NARROW_W
) (
    input wire logic clk,                                   // 25 MHz timer clock
    input wire logic rst_b,                                 // async reset, active low
    input wire logic dbg_halt_i,                            // core halted for debug
    input wire logic [4:0] freeze_i,                        // freeze per timer in debug
    input wire logic [4:0] en_i,                            // counter enable per timer
    input wire logic [1:0] dir_down_i,                      // down count, dual timers
    input wire logic [1:0] enc_mode_i,                      // encoder mode, dual timers
    input wire logic [1:0] hall_mode_i,                     // hall mode, dual timers
    input wire logic [1:0][1:0] trig_sel_i,                 // trigger source, dual timers
    input wire logic adv_trig_i,                            // pulse from advanced control timer
    input wire logic [4:0][15:0] psc_i,                     // prescaler values
    input wire logic [4:0][WIDE_W-1:0] arr_i,               // reload values
    input wire logic [4:0][3:0][1:0] mode_i,                // channel modes
    input wire logic [4:0][3:0][WIDE_W-1:0] cmp_i,          // compare values
    input wire logic [4:0][3:0] ch_pin_i,                   // channel input pins
    output wire logic [4:0][WIDE_W-1:0] cnt_o,              // counter values
    output wire logic [4:0] upd_o,                          // update pulses
    output wire logic [1:0] trig_out_o,                     // chain pulses, dual timers
    output wire logic [4:0][3:0] ch_out_o,                  // channel outputs
    output wire logic [4:0][3:0][WIDE_W-1:0] cap_o,         // captured values
    output wire logic [4:0][3:0] cc_o,                      // channel event pulses
    output wire logic [1:0] dma_o                           // dma requests, dual timers
);
    logic [19:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic [1:0] trig_w;

    // three-stage sync; a level counts only when stages two and three agree
    always_comb begin
        filt_nxt = filt_r;
        for (int b = 0; b < 20; b++) begin
            if (s2_r[b] == s3_r[b]) begin
                filt_nxt[b] = s3_r[b];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= 20'h0;
            s2_r <= 20'h0;
            s3_r <= 20'h0;
            filt_r <= 20'h0;
        end else begin
            s1_r <= ch_pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    for (genvar d = 0; d < 2; d++) begin : g_trig
        assign trig_w[d] = (trig_sel_i[d] == timer_set_pkg::TRIG_ADVANCED) ? adv_trig_i :
                           (trig_sel_i[d] == timer_set_pkg::TRIG_PARTNER) ? upd_o[1-d] : 1'b0;
        assign trig_out_o[d] = upd_o[d];
    end

    // every slot is a time base with pwm-capable channels
    for (genvar i = 0; i < timer_set_pkg::NUM_TIMERS; i++) begin : g_tmr
        localparam int CW = (i == timer_set_pkg::WIDE_IDX) ? WIDE_W : NARROW_W;
        localparam bit DUAL = (i < timer_set_pkg::FIRST_SINGLE_IDX);
        localparam int NCH = DUAL ? timer_set_pkg::DUAL_CH : timer_set_pkg::SINGLE_CH;
        logic [NCH-1:0][1:0] mode_w;
        logic [NCH-1:0][CW-1:0] cmp_w, cap_w;
        logic [NCH-1:0] out_w, cc_w;
        logic [CW-1:0] cnt_w;
        logic dma_w;

        for (genvar k = 0; k < timer_set_pkg::MAX_CH; k++) begin : g_ch
            if (k < NCH) begin : g_used
                assign mode_w[k] = mode_i[i][k];
                assign cmp_w[k] = cmp_i[i][k][CW-1:0];
                assign cap_o[i][k] = WIDE_W'(cap_w[k]);
                assign ch_out_o[i][k] = out_w[k];
                assign cc_o[i][k] = cc_w[k];
            end else begin : g_idle
                assign cap_o[i][k] = '0;
                assign ch_out_o[i][k] = 1'b0;
                assign cc_o[i][k] = 1'b0;
            end
        end

        timer_core #(
            .CW(CW),
            .NCH(NCH),
            .DIR_EN(DUAL)
        ) i_timer_core (
            .clk(clk),
            .rst_b(rst_b),
            .en_i(en_i[i]),
            .dir_down_i(DUAL ? dir_down_i[DUAL ? i : 0] : 1'b0),
            .run_i(!(dbg_halt_i && freeze_i[i])),
            .enc_mode_i(DUAL ? enc_mode_i[DUAL ? i : 0] : 1'b0),
            .hall_mode_i(DUAL ? hall_mode_i[DUAL ? i : 0] : 1'b0),
            .trig_i(DUAL ? trig_w[DUAL ? i : 0] : 1'b0),
            .psc_i(psc_i[i]),
            .arr_i(arr_i[i][CW-1:0]),
            .mode_i(mode_w),
            .cmp_i(cmp_w),
            // encoder and hall lines come through the channel inputs
            .ch_in_i(filt_r[i*4 +: NCH]),
            .cnt_o(cnt_w),
            .upd_o(upd_o[i]),
            .ch_out_o(out_w),
            .cap_o(cap_w),
            .cc_o(cc_w),
            .dma_o(dma_w)
        );
        assign cnt_o[i] = WIDE_W'(cnt_w);
        if (DUAL) begin : g_dma
            assign dma_o[i] = dma_w;
        end
    end
endmodule

`default_nettype wire

// >>> quad_encoder_model.sv
// quadrature encoder model driving two channel pins of a dual-direction timer
`timescale 1ns/10ps
`default_nettype none

module quad_encoder_model (
    input wire logic clk,      // bench clock
    input wire logic rst_b,    // async reset, active low
    input wire logic step_i,   // move one edge this cycle
    input wire logic back_i,   // move backwards
    output logic a_o,          // first phase line
    output logic b_o           // second phase line
);
    logic [1:0] ph_r;
    logic [1:0] ph_nxt;

    always_comb begin
        ph_nxt = ph_r;
        if (step_i) begin
            ph_nxt = back_i ? ph_r - 2'h1 : ph_r + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_r <= 2'h0;
        end else begin
            ph_r <= ph_nxt;
        end
    end

    // only one line changes per step, as a real encoder disc does
    assign a_o = ph_r[1] ^ ph_r[0];
    assign b_o = ph_r[1];
endmodule

`default_nettype wire

// >>> tb_general_purpose_timer_set.sv
// self-checking bench for the general purpose timer set
`timescale 1ns/10ps
`default_nettype none

module tb_general_purpose_timer_set;
    logic clk, rst_b, halt, adv, step, back, chk_on;
    logic [4:0] en, frz;
    logic [1:0] dn, enm, hm;
    logic [1:0][1:0] tsel;
    logic [4:0][15:0] psc;
    logic [4:0][31:0] arr;
    logic [4:0][3:0][1:0] md;
    logic [4:0][3:0][31:0] cmp;
    logic [4:0][3:0] pins;
    wire logic [4:0][3:0] ch_pin;
    wire logic [4:0][31:0] cnt_o;
    wire logic [4:0] upd_o;
    wire logic [1:0] trig_out_o, dma_o;
    wire logic [4:0][3:0] ch_out_o, cc_o;
    wire logic [4:0][3:0][31:0] cap_o;
    wire logic ea, eb;
    logic [31:0] cn[5];
    int pc[5], pa[5];
    logic [4:0] eu, ech, old;
    logic run, tr, stp;
    logic [4:0][3:0] eo, ed, ecc;
    int fail_count, checked, n;
    logic [31:0] seed, save;

    general_purpose_timer_set i_general_purpose_timer_set (.clk(clk), .rst_b(rst_b),
        .dbg_halt_i(halt), .freeze_i(frz), .en_i(en), .dir_down_i(dn), .enc_mode_i(enm),
        .hall_mode_i(hm), .trig_sel_i(tsel), .adv_trig_i(adv), .psc_i(psc), .arr_i(arr),
        .mode_i(md), .cmp_i(cmp), .ch_pin_i(ch_pin), .cnt_o(cnt_o), .upd_o(upd_o),
        .trig_out_o(trig_out_o), .ch_out_o(ch_out_o), .cap_o(cap_o), .cc_o(cc_o),
        .dma_o(dma_o));

    quad_encoder_model i_quad_encoder_model (.clk(clk), .rst_b(rst_b), .step_i(step),
        .back_i(back), .a_o(ea), .b_o(eb));

    assign ch_pin = {pins[4:1], pins[0][3:2], eb, ea};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // reference counters, stepped with the same sampled inputs as the design
    always @(posedge clk or negedge rst_b) begin
        old = eu;
        for (int i = 0; i < 5; i++) begin
            if (!rst_b) begin
                cn[i] = 32'h0; pc[i] = 0; pa[i] = 0; eu[i] = 1'b0; ech[i] = 1'b0;
                eo[i] = 4'h0;
                ed[i] = 4'h0;
                ecc[i] = 4'h0;
            end else begin
                run = en[i] && !(halt && frz[i]);
                ech[i] = cn[i] < cmp[i][0];
                tr = (i < 2) && (tsel[i] == 2'h1 ? adv : tsel[i] == 2'h2 ? old[1 - i] : 1'b0);
                stp = run && !tr && pc[i] == pa[i];
                // channel outputs follow the count held before this edge
                for (int c = 0; c < 4; c++) begin
                    ecc[i][c] = 1'b0;
                    case (md[i][c])
                        timer_set_pkg::MODE_COMPARE: begin
                            if (stp && cn[i] == cmp[i][c]) begin
                                eo[i][c] = !eo[i][c];
                                ecc[i][c] = 1'b1;
                            end
                        end
                        timer_set_pkg::MODE_PWM: eo[i][c] = cn[i] < cmp[i][c];
                        timer_set_pkg::MODE_ONE_PULSE: begin
                            eo[i][c] = !ed[i][c] && en[i] && cn[i] < cmp[i][c];
                        end
                        default: eo[i][c] = 1'b0;
                    endcase
                    // single-channel slots leave channels 1 to 3 idle
                    if (c > 0 && i > 1) begin
                        eo[i][c] = 1'b0;
                        ecc[i][c] = 1'b0;
                    end
                end
                eu[i] = 1'b0;
                if (run && tr) begin
                    cn[i] = 32'h0; pc[i] = 0; eu[i] = 1'b1;
                end else if (run && pc[i] == pa[i]) begin
                    pc[i] = 0;
                    if (i < 2 && dn[i]) begin
                        if (cn[i] == 32'h0) begin cn[i] = arr[i]; eu[i] = 1'b1; end
                        else cn[i] = cn[i] - 32'h1;
                    end else if (cn[i] >= arr[i]) begin
                        cn[i] = 32'h0; eu[i] = 1'b1;
                    end else cn[i] = cn[i] + 32'h1;
                end else if (run) pc[i]++;
                if (eu[i]) pa[i] = int'(psc[i]);
                // one pulse per enable: spent at update, re-armed by a low enable
                for (int c = 0; c < 4; c++) begin
                    if (eu[i] && md[i][c] == timer_set_pkg::MODE_ONE_PULSE) ed[i][c] = 1'b1;
                    if (!en[i]) ed[i][c] = 1'b0;
                end
            end
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(negedge clk) begin
        if (chk_on) begin
            for (int i = 0; i < 5; i++) begin
                check("counter", cnt_o[i], cn[i]);
                check("update", 32'(upd_o[i]), 32'(eu[i]));
                if (md[i][0] == timer_set_pkg::MODE_PWM)
                    check("pwm output", 32'(ch_out_o[i][0]), 32'(ech[i]));
                check("channel outputs", 32'(ch_out_o[i]), 32'(eo[i]));
            end
            for (int i = 0; i < 2; i++) begin
                check("channel events", 32'(cc_o[i]), 32'(ecc[i]));
                check("dma", 32'(dma_o[i]), 32'(eu[i] | (|ecc[i])));
                check("chain", 32'(trig_out_o[i]), 32'(eu[i]));
            end
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // narrow ranges keep wraps frequent; slot 0 sometimes gets a full 32-bit reload
    task automatic shake();
        for (int i = 0; i < 5; i++) begin
            psc[i] = 16'($random(seed) & 3);
            arr[i] = 32'($random(seed) & 7);
            cmp[i][0] = 32'($random(seed) & 15);
            for (int c = 1; c < 4; c++) md[i][c] = 2'($random(seed));
        end
        if ($random(seed) & 1) arr[0] = $random(seed);
        en = 5'($random(seed)) | 5'h0c;
        dn = 2'($random(seed));
        halt = 1'(($random(seed) & 3) == 0);
        frz = 5'($random(seed));
        for (int i = 0; i < 2; i++) tsel[i] = 2'($unsigned($random(seed)) % 3);
    endtask

    task automatic enc(input int k, input logic b);
        repeat (k) begin
            step = 1'b1; back = b; cyc(1);
            step = 1'b0; cyc(7);
        end
    endtask

    initial begin
        seed = 32'h5585dd05;
        fail_count = 0; checked = 0; chk_on = 1'b1; rst_b = 1'b0;
        halt = 1'b0; adv = 1'b0; step = 1'b0; back = 1'b0;
        en = 5'h0; frz = 5'h0; dn = 2'h0; enm = 2'h0; hm = 2'h0; tsel = '0;
        psc = '0; arr = '0; cmp = '0; pins = '0;
        for (int i = 0; i < 5; i++) md[i] = {4{timer_set_pkg::MODE_PWM}};
        cyc(10);
        rst_b = 1'b1;
        for (int k = 0; k < 40; k++) begin
            shake();
            repeat (30) begin
                adv = 1'(($random(seed) & 7) == 0);
                cyc(1);
            end
        end
        adv = 1'b0; halt = 1'b0; en = 5'h1f; tsel = '0;
        md[2][0] = timer_set_pkg::MODE_CAPTURE;
        cyc(3);
        pins[2][0] = 1'b1;
        n = 0;
        while (cc_o[2][0] !== 1'b1 && n < 10) begin
            save = cn[2];
            @(negedge clk);
            n++;
        end
        // three sync stages, the agree stage and the capture register, seen at the sixth negedge
        check("capture delay", 32'(n), 32'h6);
        check("captured value", cap_o[2][0], save);
        cyc(1);
        rst_b = 1'b0; chk_on = 1'b0;
        cyc(2);
        rst_b = 1'b1; psc = '0; arr[0] = 32'h64; dn = 2'h0; enm = 2'h1;
        cyc(2);
        enc(8, 1'b0);
        check("encoder forward", cnt_o[0], 32'h4);
        enc(6, 1'b1);
        check("encoder back", cnt_o[0], 32'h1);
        hm = 2'h2; md[1][0] = timer_set_pkg::MODE_CAPTURE;
        cyc(8);
        pins[1][2] = 1'b1;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            if (cc_o[1][0] === 1'b1) n++;
        end
        check("hall captures", 32'(n), 32'h1);
        final_report();
    end

    initial begin
        #(40 * 6000);
        fail_count++;
        final_report();
    end
endmodule

`default_nettype wire
